/* File: common/fsl_consts.svh */
// Purpose: Constants for the isolated serial link block
// Assumes: Included by bare name from design files
// Notes:   Rule overview follows
// Overview of operation
// - Link traffic always uses the channel B pins when any channel enables it
// - Link enables come from nonvolatile configuration bits, not pin straps
// - Bit-mode value 10 holds link in reset; input still accepted; 0 resumes
// - A ready byte starts its frame with a low start bit
// - No outgoing frame starts while an incoming frame is being received
// - Outgoing data bits go least significant bit first
// - Last outgoing bit names origin channel: 0 for A, 1 for B
// - Low start bit seen drops clear-to-send on the next rising clock edge
// - Incoming frame is start bit 0, then eight data bits LSB first
// - Last incoming bit routes byte; disabled target falls to other channel
// - With no channel enabled the whole link stays inactive
// - Clear-to-send stays low until another incoming byte can be taken
// - Outgoing frame is start, eight data, channel bit; one bit per clock
`ifndef FSL_CONSTS_SVH
`define FSL_CONSTS_SVH
`define FSL_DATA_BITS   8
`define FSL_FRAME_BITS  10
`define FSL_BMODE_RESET 8'h10
`define FSL_BMODE_RUN   8'h00
`define FSL_FIFO_DEPTH  4
`endif

/* File: common/fsl_pkg.sv */
// Purpose: Types for the isolated serial link block
// Assumes: Constants live in fsl_consts.svh
// Notes:   Types only
package fsl_pkg;
  typedef logic [7:0] fsl_byte_t;
  typedef enum logic [1:0] {FSL_TX_IDLE, FSL_TX_SHIFT} fsl_tx_state_t;
  typedef enum logic [1:0] {FSL_RX_IDLE, FSL_RX_SHIFT, FSL_RX_HOLD}
    fsl_rx_state_t;
endpackage

/* File: rtl/fsl_fifo.sv */
// Purpose: Small valid/ready FIFO on the outgoing byte path
// Assumes: Single clock, synchronous active-high reset
// Notes:   Read data is read combinationally from the storage array
`timescale 1ns/1ps
`default_nettype none
module fsl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshake terms; a held output word counts as occupying a slot
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign push    = inValid && inReady;
  assign pop     = outReady && (count_r != '0);
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers and fill count
  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/fsl_link.sv */
// Purpose: Device end of the four-wire isolated serial link
// Assumes: Link clock and data pins are asynchronous to mclk
// Notes:   Serial output changes one mclk after the sampled rising link edge
//          and holds its value until the next one while running; clear-to-send drops at a link edge or when both enables clear, and returns without one
`timescale 1ns/1ps
`default_nettype none
`include "fsl_consts.svh"
module fsl_link (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             cfgLinkA,
  input  wire logic             cfgLinkB,
  input  wire logic       [7:0] bitMode,
  input  wire logic             bitModeWr,
  input  wire fsl_pkg::fsl_byte_t txDataA,
  input  wire logic             txValidA,
  output logic                  txReadyA,
  input  wire fsl_pkg::fsl_byte_t txDataB,
  input  wire logic             txValidB,
  output logic                  txReadyB,
  output fsl_pkg::fsl_byte_t    rxData,
  output logic                  rxValidA,
  output logic                  rxValidB,
  input  wire logic             rxReady,
  input  wire logic             link_clock_in,
  input  wire logic             serial_in_line,
  output logic                  serial_out_line,
  output logic                  link_clear_to_send,
  output logic                  linkPinsOwned,
  output logic                  linkHeld
);
  import fsl_pkg::*;

  // Pin synchronisers and link edge
  logic [1:0]  clkSync_r;
  logic [1:0]  dinSync_r;
  logic        clkPrev_r;
  logic        rise;
  // Enables and hold
  logic        active;
  logic        run;
  logic        held_r;
  // Transmit and receive shifters
  fsl_tx_state_t txState_r;
  fsl_rx_state_t rxState_r;
  logic [8:0]  txShift_r;
  logic [3:0]  txCnt_r;
  logic [7:0]  rxShift_r;
  logic [3:0]  rxCnt_r;
  logic        rxDest_r;
  // Pin and host-side registers
  logic        sdo_r;
  logic        cts_r;
  logic        own_r;
  logic        rxValidA_r;
  logic        rxValidB_r;
  logic [7:0]  rxData_r;
  // Outgoing byte queue
  logic [8:0]  fifoIn;
  logic        fifoInValid;
  logic        fifoInReady;
  logic [8:0]  fifoOut;
  logic        fifoOutValid;
  logic        fifoPop;
  logic        pickB_r;

  // Channel route for an incoming byte, falling to the enabled other one
  function automatic logic routeToB(input logic target_channel_bit, input logic enA,
                                    input logic enB);
    routeToB = target_channel_bit ? enB : !enA;
  endfunction

  // Two-stage synchronisers for the link pins
  always_ff @(posedge mclk) begin
    if (srst) begin
      clkSync_r <= 2'h0;
      dinSync_r <= 2'h3;
      clkPrev_r <= 1'b0;
    end else begin
      clkSync_r <= {clkSync_r[0], link_clock_in};
      dinSync_r <= {dinSync_r[0], serial_in_line};
      clkPrev_r <= clkSync_r[1];
    end
  end

  // Rising link edge found from the synchronised level
  assign rise = clkSync_r[1] && !clkPrev_r;
  assign active = cfgLinkA || cfgLinkB;
  assign run = active && !held_r;

  // Bit-mode hold state
  always_ff @(posedge mclk) begin
    if (srst) begin
      held_r <= 1'b0;
    end else if (bitModeWr) begin
      if (bitMode == `FSL_BMODE_RESET) begin
        held_r <= 1'b1;
      end else if (bitMode == `FSL_BMODE_RUN) begin
        held_r <= 1'b0;
      end
    end
  end

  // Pins belong to channel B whenever any channel enables the link
  always_ff @(posedge mclk) begin
    if (srst) begin
      own_r <= 1'b0;
    end else begin
      own_r <= active;
    end
  end

  // Host bytes are taken even while held; alternate A and B fairly
  always_ff @(posedge mclk) begin
    if (srst) begin
      pickB_r <= 1'b0;
    end else if (fifoInValid && fifoInReady) begin
      pickB_r <= !fifoIn[8];
    end
  end

  // Source select into the FIFO; bit 8 carries the origin channel
  always_comb begin
    fifoIn = 9'h000;
    fifoInValid = 1'b0;
    txReadyA = 1'b0;
    txReadyB = 1'b0;
    if (active) begin
      if (txValidB && cfgLinkB && (pickB_r || !(txValidA && cfgLinkA))) begin
        fifoIn = {1'b1, txDataB};
        fifoInValid = 1'b1;
        txReadyB = fifoInReady;
      end else if (txValidA && cfgLinkA) begin
        fifoIn = {1'b0, txDataA};
        fifoInValid = 1'b1;
        txReadyA = fifoInReady;
      end
    end
  end

  fsl_fifo #(
    .WIDTH (9),
    .DEPTH (`FSL_FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .srst     (srst),
    .inData   (fifoIn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // Start a frame only when idle in both directions and released
  assign fifoPop = run && rise && (txState_r == FSL_TX_IDLE) && fifoOutValid
                   && (rxState_r == FSL_RX_IDLE) && dinSync_r[1];

  // Transmit shifter, paced only by the far party's clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      txState_r <= FSL_TX_IDLE;
      txShift_r <= 9'h000;
      txCnt_r   <= 4'h0;
      sdo_r     <= 1'b1;
    end else if (!run) begin
      txState_r <= FSL_TX_IDLE;
      txCnt_r   <= 4'h0;
      sdo_r     <= 1'b1;
    end else if (rise) begin
      case (txState_r)
        FSL_TX_IDLE: begin
          if (fifoPop) begin
            sdo_r     <= 1'b0;
            txShift_r <= fifoOut; // Data then origin bit
            txCnt_r   <= 4'h0;
            txState_r <= FSL_TX_SHIFT;
          end else begin
            // High only at a link edge, so the origin bit stands a period
            sdo_r     <= 1'b1;
          end
        end
        FSL_TX_SHIFT: begin
          // One bit each link clock, LSB first
          sdo_r     <= txShift_r[0];
          txShift_r <= {1'b1, txShift_r[8:1]};
          if (txCnt_r == 4'(`FSL_FRAME_BITS - 2)) begin
            txState_r <= FSL_TX_IDLE;
          end
          txCnt_r <= txCnt_r + 4'h1;
        end
        default: txState_r <= FSL_TX_IDLE;
      endcase
    end
  end

  // Receive shifter and clear-to-send
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxState_r  <= FSL_RX_IDLE;
      rxShift_r  <= 8'h00;
      rxCnt_r    <= 4'h0;
      rxDest_r   <= 1'b0;
      cts_r      <= 1'b0;
      rxValidA_r <= 1'b0;
      rxValidB_r <= 1'b0;
      rxData_r   <= 8'h00;
    end else begin
      case (rxState_r)
        FSL_RX_IDLE: begin
          cts_r <= active && !(rxValidA_r || rxValidB_r);
          if (active && rise && !dinSync_r[1] && cts_r) begin
            cts_r     <= 1'b0;
            rxCnt_r   <= 4'h0;
            rxState_r <= FSL_RX_SHIFT;
          end
        end
        FSL_RX_SHIFT: begin
          cts_r <= 1'b0;
          if (rise) begin
            if (rxCnt_r < 4'(`FSL_DATA_BITS)) begin
              rxShift_r <= {dinSync_r[1], rxShift_r[7:1]};
            end else begin
              rxDest_r  <= dinSync_r[1];
              rxState_r <= FSL_RX_HOLD;
            end
            rxCnt_r <= rxCnt_r + 4'h1;
          end
        end
        FSL_RX_HOLD: begin
          // Deliver to the routed channel
          rxData_r <= rxShift_r;
          if (routeToB(rxDest_r, cfgLinkA, cfgLinkB)) begin
            rxValidB_r <= 1'b1;
          end else begin
            rxValidA_r <= 1'b1;
          end
          rxState_r <= FSL_RX_IDLE;
        end
        default: rxState_r <= FSL_RX_IDLE;
      endcase
      if ((rxValidA_r || rxValidB_r) && rxReady) begin
        rxValidA_r <= 1'b0;
        rxValidB_r <= 1'b0;
      end
    end
  end

  // Pins and host outputs straight from their registers
  assign serial_out_line    = sdo_r;
  assign link_clear_to_send = cts_r;
  assign rxData             = rxData_r;
  assign rxValidA           = rxValidA_r;
  assign rxValidB           = rxValidB_r;
  assign linkPinsOwned      = own_r;
  assign linkHeld           = held_r;

  // Checks and scenarios
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Transmit side: start bit, bit order, frame length, quiet states
  start_bit_low_a: assert property (fifoPop |=> !serial_out_line)
    else $error("start bit not low");

  no_tx_rx_a: assert property ((rise && rxState_r != FSL_RX_IDLE
                && txState_r == FSL_TX_IDLE) |=> serial_out_line
                && (txState_r == FSL_TX_IDLE))
    else $error("frame started during receive");

  lsb_first_a: assert property ((txState_r == FSL_TX_SHIFT
                 && run && rise) |=> serial_out_line == $past(txShift_r[0]))
    else $error("data bit out of order");

  origin_a: assert property (fifoPop |=>
              txShift_r[8] == $past(fifoOut[8]))
    else $error("origin bit lost");

  tx_len_a: assert property ((txState_r == FSL_TX_SHIFT && rise
              && txCnt_r == 4'(`FSL_FRAME_BITS - 2))
              |=> (txState_r == FSL_TX_IDLE))
    else $error("frame length wrong");

  bit_stand_a: assert property ((run && !rise) |=>
                 $stable(serial_out_line))
    else $error("bit changed between link edges");

  held_quiet_a: assert property ((held_r && $past(held_r)) |->
                  serial_out_line && (txState_r == FSL_TX_IDLE))
    else $error("sent while held");

  off_quiet_a: assert property (!active |=> serial_out_line)
    else $error("sent while disabled");

  // Receive side: clear-to-send, shifting and delivery
  cts_drop_a: assert property ((rxState_r == FSL_RX_IDLE && active
                && rise && !dinSync_r[1] && cts_r) |=> !link_clear_to_send)
    else $error("clear-to-send not dropped");

  cts_low_a: assert property ((rxState_r == FSL_RX_SHIFT) |=>
               !link_clear_to_send)
    else $error("clear-to-send rose mid frame");

  cts_back_a: assert property ((rxState_r == FSL_RX_IDLE && active
                && !rxValidA_r && !rxValidB_r
                && !(rise && !dinSync_r[1] && cts_r)) |=> link_clear_to_send)
    else $error("clear-to-send did not return");

  inactive_a: assert property (!active |=> !link_clear_to_send
                && !fifoPop)
    else $error("link acted while disabled");

  rx_lsb_a: assert property ((rxState_r == FSL_RX_SHIFT && rise
              && rxCnt_r < 4'(`FSL_DATA_BITS))
              |=> rxShift_r[7] == $past(dinSync_r[1]))
    else $error("data bit shifted wrong");

  rx_data_a: assert property ((rxState_r == FSL_RX_HOLD) |=>
               rxData == $past(rxShift_r))
    else $error("received byte lost");

  rx_deliver_a: assert property ((rxState_r == FSL_RX_HOLD) |=>
                  (rxValidA_r != rxValidB_r))
    else $error("received byte not delivered");

  route_a: assert property ((rxState_r == FSL_RX_HOLD && cfgLinkA
             && cfgLinkB) |=> (rxValidB == $past(rxDest_r)))
    else $error("byte routed wrong");

  fallback_a: assert property ((rxState_r == FSL_RX_HOLD
                && cfgLinkA != cfgLinkB) |=> (rxValidB == $past(cfgLinkB)))
    else $error("byte not sent to the enabled channel");

  // Pin ownership follows the enables
  own_pins_a: assert property (active |=> linkPinsOwned)
    else $error("pins not switched");

  own_off_a: assert property (!active |=> !linkPinsOwned)
    else $error("pins kept while disabled");

  // Main scenarios
  send_c: cover property (fifoPop);
  recv_a_c: cover property (rxValidA_r && rxReady);
  recv_b_c: cover property (rxValidB_r && rxReady);
  hold_c: cover property (held_r && fifoInValid && fifoInReady);
  fall_c: cover property (rxState_r == FSL_RX_HOLD && !cfgLinkA);
endmodule
`default_nettype wire

/* File: verif/fsl_far_end.sv */
// Purpose: Far-end model that clocks the link and trades frames
// Assumes: Link clock period 800 ns, still between frames
// Notes:   Input line idles high as if pulled up
`timescale 1ns/1ps
`default_nettype none
module fsl_far_end (
  output logic      link_clock_in,
  output logic      serial_in_line,
  input  wire logic serial_out_line,
  input  wire logic link_clear_to_send
);
  int   ctsErr;
  int   txLow;
  logic sdoS;
  logic ctsS;
  // Clock stands still, data line released high
  initial begin
    link_clock_in = 1'b0;
    serial_in_line = 1'b1;
    ctsErr = 0;
    txLow = 0;
  end
  // One link period, pins sampled at the rising edge
  task automatic rise();
    #400 link_clock_in = 1'b1;
    sdoS = serial_out_line;
    ctsS = link_clear_to_send;
    #400 link_clock_in = 1'b0;
  endtask
  // Start bit, data LSB first, target bit; waits up to 5 us for clear-to-send, then sends anyway
  task automatic send(input logic [7:0] d, input logic target_channel_bit);
    logic [9:0] f;
    f = {target_channel_bit, d, 1'b0};
    for (int k = 0; k < 50 && link_clear_to_send !== 1'b1; k++) #100;
    for (int i = 0; i < 10; i++) begin
      serial_in_line = f[i];
      rise();
      if (i > 0 && ctsS !== 1'b0) ctsErr++;
      if (sdoS !== 1'b1) txLow++;
    end
    serial_in_line = 1'b1;
  endtask
  // Hunt for a start bit, optionally stall, then take nine bits
  task automatic recv(input int stall, input int tries,
                      output logic [8:0] got, output logic found);
    found = 1'b0;
    got = '0;
    for (int i = 0; i < tries && !found; i++) begin
      rise();
      found = (sdoS === 1'b0);
    end
    if (found) begin
      #(stall);
      for (int i = 0; i < 9; i++) begin
        rise();
        got[i] = sdoS;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/fsl_link_tb.sv */
// Purpose: Self-checking bench for the isolated serial link
// Assumes: Far-end model makes the link clock; 10 MHz mclk
// Notes:   Each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
`include "fsl_consts.svh"
module fsl_link_tb;
  import fsl_pkg::*;
  logic       mclk, srst, cfgLinkA, cfgLinkB, bitModeWr, rxReady;
  logic       txValidA, txValidB, txReadyA, txReadyB, rxValidA, rxValidB;
  logic       link_clock_in, serial_in_line, serial_out_line;
  logic       link_clear_to_send, linkPinsOwned, linkHeld, found;
  logic [7:0] bitMode;
  logic [8:0] got;
  fsl_byte_t  txDataA, txDataB, rxData;
  int         n_errors, total_checks;
  int         cycles = 0;
  fsl_link dut (.mclk, .srst, .cfgLinkA, .cfgLinkB, .bitMode, .bitModeWr,
    .txDataA, .txValidA, .txReadyA, .txDataB, .txValidB, .txReadyB,
    .rxData, .rxValidA, .rxValidB, .rxReady, .link_clock_in,
    .serial_in_line, .serial_out_line, .link_clear_to_send,
    .linkPinsOwned, .linkHeld);
  fsl_far_end far (.link_clock_in, .serial_in_line, .serial_out_line,
    .link_clear_to_send);
  // Clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Host hands one byte to a channel
  task automatic push(input logic ch, input fsl_byte_t d);
    logic r;
    @(posedge mclk);
    txDataA <= d;
    txDataB <= d;
    txValidA <= !ch;
    txValidB <= ch;
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      r = ch ? txReadyB : txReadyA;
      if (r === 1'b1) break;
    end
    check("tx ready", {8'h00, r}, 9'h001);
    @(posedge mclk);
    txValidA <= 1'b0;
    txValidB <= 1'b0;
  endtask
  // Collect one received byte and see clear-to-send return
  task automatic get_rx(input logic ch, input fsl_byte_t d);
    for (int k = 0; k < 50 && !(rxValidA | rxValidB); k++) @(negedge mclk);
    check("rx chan", {7'h00, rxValidB, rxValidA}, ch ? 9'h002 : 9'h001);
    check("rx data", {1'b0, rxData}, {1'b0, d});
    check("cts held", {8'h00, link_clear_to_send}, 9'h000);
    @(posedge mclk);
    rxReady <= 1'b1;
    @(posedge mclk);
    rxReady <= 1'b0;
    for (int k = 0; k < 20 && link_clear_to_send !== 1'b1; k++) @(negedge mclk);
    check("cts back", {8'h00, link_clear_to_send}, 9'h001);
  endtask
  task automatic wr_mode(input logic [7:0] m);
    @(posedge mclk);
    bitMode <= m;
    bitModeWr <= 1'b1;
    @(posedge mclk);
    bitModeWr <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_reset();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check("sdo rst", {8'h00, serial_out_line}, 9'h001);
    check("cts rst", {8'h00, link_clear_to_send}, 9'h000);
    @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(negedge mclk);
    check("cts up", {8'h00, link_clear_to_send}, 9'h001);
    check("pins", {8'h00, linkPinsOwned}, 9'h001);
    $display("reset test done");
  endtask
  // Two queued bytes, the second read with a stalled clock
  task automatic t_tx();
    fsl_byte_t v [2] = '{8'hA5, 8'h3C};
    push(1'b0, v[0]);
    push(1'b1, v[1]);
    for (int i = 0; i < 2; i++) begin
      far.recv(i * 3000, 20, got, found);
      check("tx start", {8'h00, found}, 9'h001);
      check("tx frame", got, {i[0], v[i]});
    end
    $display("tx test done");
  endtask
  // Routing over enable combinations, including fallback
  task automatic t_rx();
    logic [3:0] c [4] = '{4'b1100, 4'b1111, 4'b0101, 4'b1010};
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      cfgLinkA <= c[i][3];
      cfgLinkB <= c[i][2];
      repeat (3) @(negedge mclk);
      check("pins", {8'h00, linkPinsOwned}, 9'h001);
      far.send(8'h5A + 8'(i), c[i][1]);
      get_rx(c[i][0], 8'h5A + 8'(i));
    end
    check("cts during rx", 9'(far.ctsErr), 9'h000);
    $display("rx test done");
  endtask
  // Host byte arrives mid-reception: no start bit until frame ends
  task automatic t_mix();
    // Both channels back on after the routing sweep
    @(posedge mclk);
    cfgLinkA <= 1'b1;
    cfgLinkB <= 1'b1;
    repeat (3) @(negedge mclk);
    fork
      far.send(8'h11, 1'b1);
      begin
        repeat (20) @(posedge mclk);
        push(1'b0, 8'h77);
      end
    join
    check("tx while rx", 9'(far.txLow), 9'h000);
    get_rx(1'b1, 8'h11);
    far.recv(0, 20, got, found);
    check("tx after rx", got, 9'h077);
    $display("mix test done");
  endtask
  task automatic t_hold();
    wr_mode(`FSL_BMODE_RESET);
    check("held", {8'h00, linkHeld}, 9'h001);
    // Any bit-mode value other than 10 or 00 leaves the hold in place
    wr_mode(8'h02);
    check("held kept", {8'h00, linkHeld}, 9'h001);
    push(1'b1, 8'hC3);
    far.recv(0, 12, got, found);
    check("held silent", {8'h00, found}, 9'h000);
    wr_mode(`FSL_BMODE_RUN);
    check("released", {8'h00, linkHeld}, 9'h000);
    far.recv(0, 12, got, found);
    check("held byte", got, 9'h1C3);
    $display("hold test done");
  endtask
  task automatic t_off();
    push(1'b0, 8'h42);
    @(posedge mclk);
    cfgLinkA <= 1'b0;
    cfgLinkB <= 1'b0;
    repeat (3) @(negedge mclk);
    check("pins off", {8'h00, linkPinsOwned}, 9'h000);
    check("cts off", {8'h00, link_clear_to_send}, 9'h000);
    far.recv(0, 12, got, found);
    check("no tx off", {8'h00, found}, 9'h000);
    $display("off test done");
  endtask
  // Main sequence
  initial begin
    srst = 1'b1;
    cfgLinkA = 1'b1;
    cfgLinkB = 1'b1;
    bitMode = `FSL_BMODE_RUN;
    bitModeWr = 1'b0;
    rxReady = 1'b0;
    txValidA = 1'b0;
    txValidB = 1'b0;
    txDataA = 8'h00;
    txDataB = 8'h00;
    n_errors = 0;
    total_checks = 0;
    t_reset();
    t_tx();
    t_rx();
    t_mix();
    t_hold();
    t_off();
    finish_test();
  end
endmodule
`default_nettype wire
